// File: iocr_board.sv
// Board model: devices on the pads and the clock trace to both clock pins.
`timescale 1ns/1ps
module iocr_board (
  // Clock and device pins
  input  wire logic       clk_sys,
  input  wire logic [3:0] pad_out,
  input  wire logic [3:0] pad_oe_n,
  input  wire logic       pullup_en,
  output logic [3:0]      pad_in,
  output logic [1:0]      ded_clk_pin,
  // Board stimulus
  input  wire logic [3:0] drv_en,
  input  wire logic [3:0] drv_val,
  input  wire logic       brd_clk
);
  logic [3:0] last_ff = 4'h0;  // A known start, or a floating pad would stay unknown.
  // One clock trace feeds both dedicated pins, so both carry the same sense.
  assign ded_clk_pin = {brd_clk, brd_clk};
  // A floating pad toggles so a stale value can never pass for a driven one.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (drv_en[i]) pad_in[i] = drv_val[i];
      else if (pullup_en) pad_in[i] = 1'b1;
      else pad_in[i] = ~last_ff[i];
    end
  end
  // Last pad level seen.
  always_ff @(posedge clk_sys) begin
    last_ff <= pad_in;
  end
endmodule // iocr_board

// File: iocr_cell.sv
// One io cell: control selection, the cell register, input delay and pad drive.
`timescale 1ns/1ps
module iocr_cell (
  // Clock, reset and freeze
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // Configuration and shared controls
  input  wire iocr_pkg::iocr_cell_cfg_s cfg,
  input  wire iocr_pkg::iocr_ctrl_s     ctrl,
  input  wire logic                     lc_ce,
  input  wire logic                     lc_oe,
  input  wire logic                     chip_rst,
  input  wire logic                     chip_tri,
  // Data paths
  input  wire logic                     pad_in,
  input  wire logic                     out_data,
  output logic                          pad_out,
  output logic                          pad_oe_n,
  output logic                          in_data,
  output logic                          reg_q
);
  logic pad_dly_ff;
  logic clk_prev_ff;
  logic reg_ff;
  logic pad_out_ff;
  logic oe_n_ff;
  logic in_path;
  logic clk_lvl;
  logic clr_lvl;
  logic ce_lvl;
  logic oe_lvl;
  logic nxt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // The delayed input adds hold margin at the cost of one stage of setup.
  always_ff @(posedge clk_sys) begin
    if (rst) pad_dly_ff <= 1'b0;
    else if (ce) pad_dly_ff <= pad_in;
  end
  assign in_path = cfg.dly_en ? pad_dly_ff : pad_in;

  // Each cell picks its own clock, clear, enable and output enable.
  always_comb begin
    unique case (cfg.clk_sel)
      iocr_pkg::CLK_SLOT0: clk_lvl = ctrl.clk[0];
      iocr_pkg::CLK_SLOT1: clk_lvl = ctrl.clk[1];
      iocr_pkg::CLK_PIN0:  clk_lvl = ctrl.ded_clk[0];
      iocr_pkg::CLK_PIN1:  clk_lvl = ctrl.ded_clk[1];
    endcase
    clr_lvl = 1'b0;
    if (cfg.clr_sel == iocr_pkg::CLR_SLOT0) clr_lvl = ctrl.clr[0];
    else if (cfg.clr_sel == iocr_pkg::CLR_SLOT1) clr_lvl = ctrl.clr[1];
    if (cfg.ce_sel < iocr_pkg::CE_LC) ce_lvl = ctrl.ce[cfg.ce_sel[2:0]];
    else if (cfg.ce_sel == iocr_pkg::CE_LC) ce_lvl = lc_ce;
    else ce_lvl = 1'b1;
    if (cfg.oe_sel < iocr_pkg::OE_LC) oe_lvl = ctrl.oe[cfg.oe_sel[2:0]];
    else if (cfg.oe_sel == iocr_pkg::OE_LC) oe_lvl = lc_oe;
    else oe_lvl = (cfg.oe_sel == iocr_pkg::OE_ON);
  end

  // The one register serves either the input or the output direction.
  assign nxt_reg = cfg.out_mode ? out_data : in_path;

  // Chip reset beats clear, clear beats a clock edge; edges come from sampling.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_prev_ff <= 1'b0;
      reg_ff      <= 1'b0;
    end else if (ce) begin
      clk_prev_ff <= clk_lvl;
      if (chip_rst) reg_ff <= 1'b0;
      else if (clr_lvl) reg_ff <= 1'b0;
      else if (clk_lvl && !clk_prev_ff && ce_lvl) reg_ff <= nxt_reg;
    end
  end

  // Pad drive is registered so the pins never glitch on select changes.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pad_out_ff <= 1'b0;
      oe_n_ff    <= 1'b1;
    end else if (ce) begin
      pad_out_ff <= (cfg.use_reg && cfg.out_mode) ? reg_ff : out_data;
      oe_n_ff    <= !(oe_lvl && !chip_tri);
    end
  end

  assign in_data  = (cfg.use_reg && !cfg.out_mode) ? reg_ff : in_path;
  assign pad_out  = pad_out_ff;
  assign pad_oe_n = oe_n_ff;
  assign reg_q    = reg_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_dly_path: assert property (ce && cfg.dly_en && !cfg.use_reg && $stable(cfg)
    |=> in_data == $past(pad_in))
    else $error("delayed input does not lag the pad by one cycle");
  a_reg_hold: assert property (ce && !chip_rst && !clr_lvl && !ce_lvl
    |=> reg_ff == $past(reg_ff))
    else $error("cell register changed with its enable low");
endmodule  // iocr_cell

// File: iocr_pkg.sv
// Package of constants and carriers for the io cell control and routing block.
package iocr_pkg;
  // Sizes of the modelled slice of the device.
  localparam int NCELL      = 4;
  localparam int NSLOT      = 12;
  localparam int NDED       = 6;
  localparam int NROW       = 3;
  localparam int NCLUS      = 4;
  localparam int ROW_CH     = 144;
  localparam int ROW_PICK   = 18;
  localparam int ROW_STRIDE = 8;
  localparam int COL_CH     = 24;
  localparam int COL_PICK   = 16;
  localparam int COL_STEP   = 2;
  localparam int NGLOB      = 4;
  // Register byte offsets.
  localparam logic [7:0] OFS_CELL_CFG  = 8'h00;
  localparam logic [7:0] OFS_SLOT_CFG  = 8'h40;
  localparam logic [7:0] OFS_GLB_CTRL  = 8'h80;
  localparam logic [7:0] OFS_CELL_STAT = 8'h84;
  localparam logic [7:0] OFS_SLOT_STAT = 8'h88;
  // Global control field positions and reset value.
  localparam int         GLB_CLK_INV = 0;
  localparam int         GLB_TRI_OPT = 1;
  localparam logic [1:0] GLB_RESET   = 2'h0;
  // Slot source codes; codes below SRC_ROW_LC pick a dedicated input pin.
  localparam logic [2:0] SRC_ROW_LC = 3'h6;
  localparam logic [2:0] SRC_COL    = 3'h7;
  // Cell select codes.
  localparam logic [1:0] CLK_SLOT0 = 2'h0;
  localparam logic [1:0] CLK_SLOT1 = 2'h1;
  localparam logic [1:0] CLK_PIN0  = 2'h2;
  localparam logic [1:0] CLK_PIN1  = 2'h3;
  localparam logic [1:0] CLR_SLOT0 = 2'h1;
  localparam logic [1:0] CLR_SLOT1 = 2'h2;
  localparam logic [3:0] CE_LC     = 4'h6;
  localparam logic [3:0] OE_LC     = 4'h8;
  localparam logic [3:0] OE_ON     = 4'h9;
  // Row that feeds each bus slot.
  localparam logic [1:0] SLOT_ROW [NSLOT] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
                                              2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

  // Per-cell configuration word.
  typedef struct packed {
    logic [4:0] out_sel;
    logic       out_col;
    logic [3:0] oe_sel;
    logic [3:0] ce_sel;
    logic [1:0] clr_sel;
    logic [1:0] clk_sel;
    logic       use_reg;
    logic       dly_en;
    logic       out_mode;
  } iocr_cell_cfg_s;
  localparam logic [20:0] CELL_CFG_RESET = 21'h007b80;

  // Per-slot source configuration.
  typedef struct packed {
    logic       alt;
    logic       inv;
    logic [1:0] clus;
    logic [2:0] src;
  } iocr_slot_cfg_s;
  localparam logic [6:0] SLOT_CFG_RESET = 7'h00;

  // Control signals as each cell sees them after role decoding.
  typedef struct packed {
    logic [7:0] oe;
    logic [5:0] ce;
    logic [1:0] clk;
    logic [1:0] clr;
    logic [1:0] ded_clk;
  } iocr_ctrl_s;
endpackage

// File: iocr_top.sv
// Io cell control bus, global nets, routing muxes and APB register file.
`timescale 1ns/1ps
module iocr_top (
  // Clock, reset and freeze
  input  wire logic                                             clk_sys,
  input  wire logic                                             rst,
  input  wire logic                                             ce,
  // APB slave
  input  wire logic [7:0]                                       paddr,
  input  wire logic                                             psel,
  input  wire logic                                             penable,
  input  wire logic                                             pwrite,
  input  wire logic [31:0]                                      pwdata,
  output logic [31:0]                                           prdata,
  output logic                                                  pready,
  output logic                                                  pslverr,
  // Device pins
  input  wire logic [iocr_pkg::NDED-1:0]                        ded_in,
  input  wire logic [1:0]                                       ded_clk_pin,
  input  wire logic                                             chip_rst_in,
  input  wire logic                                             chip_oe_in,
  input  wire logic [iocr_pkg::NCELL-1:0]                       pad_in,
  output logic [iocr_pkg::NCELL-1:0]                            pad_out,
  output logic [iocr_pkg::NCELL-1:0]                            pad_oe_n,
  output logic                                                  pullup_en,
  // Fabric side
  input  wire logic [iocr_pkg::NROW*iocr_pkg::NCLUS-1:0]        lc_first,
  input  wire logic [iocr_pkg::NROW-1:0]                        col_to_row,
  input  wire logic [iocr_pkg::NCELL-1:0]                       lc_ce,
  input  wire logic [iocr_pkg::NCELL-1:0]                       lc_oe,
  input  wire logic [iocr_pkg::ROW_CH-1:0]                      row_ch_in,
  input  wire logic [iocr_pkg::COL_CH-1:0]                      col_ch_in,
  output logic [2*iocr_pkg::NCELL-1:0]                          row_drive,
  output logic [2*iocr_pkg::NCELL-1:0]                          col_drive,
  output logic [iocr_pkg::NGLOB-1:0]                            low_skew_net
);
  iocr_pkg::iocr_cell_cfg_s               cell_cfg_ff [iocr_pkg::NCELL];
  iocr_pkg::iocr_slot_cfg_s               slot_cfg_ff [iocr_pkg::NSLOT];
  logic [1:0]                             glb_ff;
  logic [iocr_pkg::NSLOT-1:0]             slot_ff;
  logic [iocr_pkg::NSLOT-1:0]             nxt_slot;
  logic [iocr_pkg::NGLOB-1:0]             glob_ff;
  logic                                   pullup_ff;
  logic [2*iocr_pkg::NCELL-1:0]           row_drv_ff;
  logic [2*iocr_pkg::NCELL-1:0]           col_drv_ff;
  logic [31:0]                            prdata_ff;
  iocr_pkg::iocr_ctrl_s                   ctrl;
  logic [iocr_pkg::NCELL-1:0]             out_data;
  logic [iocr_pkg::NCELL-1:0]             in_data;
  logic [iocr_pkg::NCELL-1:0]             cell_q;
  logic [iocr_pkg::NSLOT-1:0]             alt;
  logic                                   chip_tri;
  logic                                   hit;
  logic                                   wr_en;
  logic [31:0]                            rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode; reads are sampled in the setup cycle, so no wait states.
  always_comb begin
    hit   = 1'b0;
    rdata = 32'h0;
    if (paddr[1:0] == 2'h0) begin
      if (paddr[7:4] == iocr_pkg::OFS_CELL_CFG[7:4]) begin
        hit   = 1'b1;
        rdata = {11'h0, cell_cfg_ff[paddr[3:2]]};
      end else if (paddr[7:6] == iocr_pkg::OFS_SLOT_CFG[7:6] && paddr[5:2] < 4'hc) begin
        hit   = 1'b1;
        rdata = {25'h0, slot_cfg_ff[paddr[5:2]]};
      end else if (paddr == iocr_pkg::OFS_GLB_CTRL) begin
        hit   = 1'b1;
        rdata = {30'h0, glb_ff};
      end else if (paddr == iocr_pkg::OFS_CELL_STAT) begin
        hit   = 1'b1;
        rdata = {20'h0, ~pad_oe_n, pad_in, cell_q};
      end else if (paddr == iocr_pkg::OFS_SLOT_STAT) begin
        hit   = 1'b1;
        rdata = {16'h0, glob_ff, slot_ff};
      end
    end
  end

  assign wr_en   = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;  // Unmapped word or misaligned address.
  assign prdata  = prdata_ff;

  // Read data is latched in setup so it stands steady through the access cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) prdata_ff <= 32'h0;
    else if (ce && psel && !penable && !pwrite) prdata_ff <= rdata;
  end

  // Configuration writes; the stored selects steer every cell and slot.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < iocr_pkg::NCELL; i++) cell_cfg_ff[i] <= iocr_pkg::CELL_CFG_RESET;
      for (int j = 0; j < iocr_pkg::NSLOT; j++) slot_cfg_ff[j] <= iocr_pkg::SLOT_CFG_RESET;
      glb_ff <= iocr_pkg::GLB_RESET;
    end else if (ce && wr_en) begin
      if (paddr[7:4] == iocr_pkg::OFS_CELL_CFG[7:4]) begin
        cell_cfg_ff[paddr[3:2]] <= pwdata[20:0];
      end else if (paddr[7:6] == iocr_pkg::OFS_SLOT_CFG[7:6]) begin
        slot_cfg_ff[paddr[5:2]] <= pwdata[6:0];
      end else if (paddr == iocr_pkg::OFS_GLB_CTRL) begin
        glb_ff <= pwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot sources: a pin, the first logic of a cluster in the slot's row, or the
  // column path into that row. Each slot carries one sense only, so true and
  // complement of one source need two slots.
  always_comb begin
    for (int j = 0; j < iocr_pkg::NSLOT; j++) begin
      if (slot_cfg_ff[j].src < iocr_pkg::SRC_ROW_LC)
        nxt_slot[j] = ded_in[slot_cfg_ff[j].src] ^ slot_cfg_ff[j].inv;
      else if (slot_cfg_ff[j].src == iocr_pkg::SRC_ROW_LC)
        nxt_slot[j] = lc_first[int'(iocr_pkg::SLOT_ROW[j]) * iocr_pkg::NCLUS
                               + int'(slot_cfg_ff[j].clus)] ^ slot_cfg_ff[j].inv;
      else
        nxt_slot[j] = col_to_row[iocr_pkg::SLOT_ROW[j]] ^ slot_cfg_ff[j].inv;
    end
  end

  // The twelve bus slots and the four low skew nets they feed.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slot_ff <= 12'h000;
      glob_ff <= 4'h0;
    end else if (ce) begin
      slot_ff <= nxt_slot;
      glob_ff <= {slot_ff[11], slot_ff[9], slot_ff[7], slot_ff[6]};
    end
  end
  assign low_skew_net = glob_ff;

  // Role decode: a dual-use slot feeds either its enable or its alternate use.
  always_comb begin
    for (int j = 0; j < iocr_pkg::NSLOT; j++) alt[j] = slot_cfg_ff[j].alt;
    ctrl.oe      = {slot_ff[9] & alt[9], slot_ff[7] & alt[7], slot_ff[5:0]};
    ctrl.ce      = slot_ff[11:6] & ~alt[11:6];
    ctrl.clk     = {slot_ff[11] & alt[11], slot_ff[6] & alt[6]};
    ctrl.clr     = {slot_ff[10] & alt[10], slot_ff[8] & alt[8]};
    ctrl.ded_clk = ded_clk_pin ^ {2{glb_ff[iocr_pkg::GLB_CLK_INV]}};
  end

  // The board may strap both clock pins to one trace; the invert option flips both alike, so both show one sense.
  assign chip_tri = glb_ff[iocr_pkg::GLB_TRI_OPT] && chip_oe_in;

  // Pull-ups follow the tristate pin so floated pads do not drift.
  always_ff @(posedge clk_sys) begin
    if (rst) pullup_ff <= 1'b0;
    else if (ce) pullup_ff <= chip_tri;
  end
  assign pullup_en = pullup_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Cells with their row and column output multiplexers.
  for (genvar i = 0; i < iocr_pkg::NCELL; i++) begin : g_cell
    // Row mux sees every eighth channel from the cell's side position; the
    // column mux sees sixteen channels starting two apart per cell.
    always_comb begin
      int ri;
      int cidx;
      ri   = int'(cell_cfg_ff[i].out_sel) * iocr_pkg::ROW_STRIDE + i % iocr_pkg::ROW_STRIDE;
      cidx = (i * iocr_pkg::COL_STEP + int'(cell_cfg_ff[i].out_sel[3:0])) % iocr_pkg::COL_CH;
      if (cell_cfg_ff[i].out_col)
        out_data[i] = col_ch_in[cidx];
      else if (int'(cell_cfg_ff[i].out_sel) < iocr_pkg::ROW_PICK)
        out_data[i] = row_ch_in[ri];
      else
        out_data[i] = 1'b0;
    end

    iocr_cell u_cell (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .cfg      (cell_cfg_ff[i]),
      .ctrl     (ctrl),
      .lc_ce    (lc_ce[i]),
      .lc_oe    (lc_oe[i]),
      .chip_rst (chip_rst_in),
      .chip_tri (chip_tri),
      .pad_in   (pad_in[i]),
      .out_data (out_data[i]),
      .pad_out  (pad_out[i]),
      .pad_oe_n (pad_oe_n[i]),
      .in_data  (in_data[i]),
      .reg_q    (cell_q[i])
    );
  end

  // Input cells drive two row and two column channels, only while not outputs.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      row_drv_ff <= 8'h00;
      col_drv_ff <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < iocr_pkg::NCELL; i++) begin
        row_drv_ff[2*i]   <= in_data[i] & ~cell_cfg_ff[i].out_mode;
        row_drv_ff[2*i+1] <= in_data[i] & ~cell_cfg_ff[i].out_mode;
        col_drv_ff[2*i]   <= in_data[i] & ~cell_cfg_ff[i].out_mode;
        col_drv_ff[2*i+1] <= in_data[i] & ~cell_cfg_ff[i].out_mode;
      end
    end
  end
  assign row_drive = row_drv_ff;
  assign col_drive = col_drv_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's outputs and internal registers.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_chip_reset_wins: assert property (ce && chip_rst_in |=> cell_q == 4'h0)
    else $error("chip reset did not clear every cell register");
  a_tri_all_pads: assert property (ce && chip_tri |=> pad_oe_n == 4'hf && pullup_en)
    else $error("tristate pin did not float pads with pull-ups on");
  a_no_tri_no_pull: assert property (ce && !chip_tri |=> !pullup_en)
    else $error("pull-ups on without the tristate pin");
  a_slot_pin_sense: assert property (ce && slot_cfg_ff[0].src == 3'h0
    |=> slot_ff[0] == ($past(ded_in[0]) ^ $past(slot_cfg_ff[0].inv)))
    else $error("slot zero does not follow its pin with its sense");
  // Both flop stages must have run out of reset for the two-cycle lag to hold.
  a_global_lag: assert property (ce && !rst ##1 ce
    |=> glob_ff == {$past(nxt_slot[11], 2), $past(nxt_slot[9], 2),
                    $past(nxt_slot[7], 2), $past(nxt_slot[6], 2)})
    else $error("low skew nets do not follow slots 6 7 9 11");
  a_role_exclusive: assert property (!(ctrl.clk[0] && ctrl.ce[0]) && !(ctrl.clr[1] && ctrl.ce[4]))
    else $error("dual use slot drives both roles");
  a_clk_sense: assert property (ctrl.ded_clk != ded_clk_pin
    |-> glb_ff[iocr_pkg::GLB_CLK_INV] && ctrl.ded_clk == ~ded_clk_pin)
    else $error("clock pins inverted unevenly");
  a_cfg_write: assert property (ce && psel && penable && pwrite && paddr == 8'h00
    |=> cell_cfg_ff[0] == $past(pwdata[20:0]))
    else $error("cell zero configuration write lost");
  a_unmapped_err: assert property (psel && penable && !hit |-> pslverr)
    else $error("unmapped access not flagged");

  c_chip_reset: cover property (ce && chip_rst_in && cell_q != 4'h0);
  c_tristate: cover property (ce && chip_tri ##1 ce && !chip_tri);
  c_cell_capture: cover property (ce && $rose(cell_q[0]));
  c_global_toggle: cover property (ce && $changed(low_skew_net));
endmodule  // iocr_top

// File: testbench.sv
// Self-checking testbench for the io cell control block.
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [7:0]  a;
    logic        wr;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } iocr_row_s;
  logic         clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, pready, pslverr, rerr;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pullup_en, brd_clk = 1'b0;
  logic         chip_rst_in = 1'b0, chip_oe_in = 1'b0;
  logic [7:0]   paddr = 8'h00, row_drive, col_drive;
  logic [31:0]  pwdata = 32'h0, prdata, rdata;
  logic [5:0]   ded_in = 6'h00;
  logic [1:0]   ded_clk_pin;
  logic [3:0]   pad_in, pad_out, pad_oe_n, low_skew_net, drv_val = 4'h0;
  logic [3:0]   lc_ce = 4'hf, lc_oe = 4'h0, drv_en = 4'h2;
  logic [11:0]  lc_first = 12'h000;
  logic [2:0]   col_to_row = 3'h0;
  logic [143:0] row_ch_in = '0;
  logic [23:0]  col_ch_in = 24'h0;
  int           n_errors = 0, samples_checked = 0, cyc = 0;
  iocr_row_s    rows [9] = '{
    '{8'h00, 1'b0, 32'h0, 32'h00007b80, 1'b0}, '{8'h40, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h80, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h00, 1'b1, '1, 32'h001fffff, 1'b0},
    '{8'h0c, 1'b1, '1, 32'h001fffff, 1'b0}, '{8'h6c, 1'b1, '1, 32'h7f, 1'b0},
    '{8'h80, 1'b1, '1, 32'h3, 1'b0}, '{8'h8c, 1'b1, '1, 32'h0, 1'b1},
    '{8'h42, 1'b1, '1, 32'h0, 1'b1}};

  iocr_top dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ded_in(ded_in), .ded_clk_pin(ded_clk_pin),
    .chip_rst_in(chip_rst_in), .chip_oe_in(chip_oe_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en), .lc_first(lc_first),
    .col_to_row(col_to_row), .lc_ce(lc_ce), .lc_oe(lc_oe), .row_ch_in(row_ch_in),
    .col_ch_in(col_ch_in), .row_drive(row_drive), .col_drive(col_drive),
    .low_skew_net(low_skew_net));
  iocr_board board (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pullup_en(pullup_en), .pad_in(pad_in), .ded_clk_pin(ded_clk_pin), .drv_en(drv_en),
    .drv_val(drv_val), .brd_clk(brd_clk));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running system clock.
  always #5 clk_sys = ~clk_sys;
  // A hang is cut short well beyond the two hundred or so cycles the run needs.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the idle edge at the end keeps psel from toggling in one step.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Moves the board clock and lets the sampled edge and register settle.
  task automatic pin(input logic v);
    brd_clk <= v;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({pad_oe_n, pullup_en}, 5'h1e);
    // Reset values, field widths and unmapped places.
    foreach (rows[k]) begin
      if (rows[k].wr) apb(rows[k].a, 1'b1, rows[k].d);
      apb(rows[k].a, 1'b0, 32'h0);
      chk(rerr, rows[k].e);
      if (!rows[k].e) chk(rdata, rows[k].r);
    end
    apb(8'h80, 1'b1, 32'h0);
    apb(8'h0c, 1'b1, 32'h7b80);
    // Slots from a pin, a cluster's first cell, a column line and an inverted pin.
    apb(8'h58, 1'b1, 32'h00);
    apb(8'h5c, 1'b1, 32'h16);
    apb(8'h64, 1'b1, 32'h07);
    apb(8'h6c, 1'b1, 32'h21);
    for (int v = 0; v < 2; v++) begin
      ded_in <= {4'h0, ~v[0], v[0]};
      lc_first <= {9'h0, v[0], 2'h0};
      col_to_row <= {1'b0, v[0], 1'b0};
      repeat (4) @(posedge clk_sys);
      chk(low_skew_net, {4{v[0]}});
    end
    ded_in <= 6'h00;
    // Cell 0: output register clocked from pin 0, enable always, drive on.
    apb(8'h00, 1'b1, 32'h4b95);
    for (int v = 1; v >= 0; v--) begin
      row_ch_in[0] <= v[0];
      pin(1'b1);
      pin(1'b0);
      chk({pad_out[0], pad_oe_n[0]}, {v[0], 1'b0});
    end
    // Clock enable straight from logic holds the register when low.
    apb(8'h00, 1'b1, 32'h4b15);
    lc_ce[0] <= 1'b0;
    row_ch_in[0] <= 1'b1;
    pin(1'b1);
    pin(1'b0);
    chk(pad_out[0], 1'b0);
    lc_ce[0] <= 1'b1;
    pin(1'b1);
    chk(pad_out[0], 1'b1);
    // Clear from slot 8, then chip reset beating a capture edge.
    apb(8'h60, 1'b1, 32'h40);
    apb(8'h00, 1'b1, 32'h4b35);
    ded_in[0] <= 1'b1;
    pin(1'b0);
    chk(pad_out[0], 1'b0);
    ded_in[0] <= 1'b0;
    // The slot takes one edge to let go of the clear, so the clock waits for it.
    pin(1'b0);
    pin(1'b1);
    chk(pad_out[0], 1'b1);
    pin(1'b0);
    chip_rst_in <= 1'b1;
    pin(1'b1);
    chk(pad_out[0], 1'b0);
    pin(1'b0);
    // Inverted pin sense: capture only when the pin falls. Chip reset stays on
    // across the flip, since the flip itself looks like an edge to the cells.
    apb(8'h80, 1'b1, 32'h1);
    chip_rst_in <= 1'b0;
    pin(1'b1);
    chk(pad_out[0], 1'b0);
    pin(1'b0);
    chk(pad_out[0], 1'b1);
    // Chip tristate pin floats every pad and turns the pull-ups on.
    apb(8'h80, 1'b1, 32'h2);
    chip_oe_in <= 1'b1;
    pin(1'b0);
    chk({pad_oe_n, pullup_en}, 5'h1f);
    chip_oe_in <= 1'b0;
    pin(1'b0);
    chk({pad_oe_n[0], pullup_en}, 2'h0);
    // Cell 1 as input, with and without the delay stage, onto two row and column lines.
    for (int k = 0; k < 4; k++) begin
      apb(8'h04, 1'b1, {16'h0, 16'h7800 | {14'h0, k[1], 1'b0}});
      drv_val[1] <= k[0];
      // One edge on, the delayed path still shows the previous pad level.
      repeat (2) @(posedge clk_sys);
      chk({row_drive[3:2], col_drive[3:2]}, {4{k[1] ^ k[0]}});
      repeat (2) @(posedge clk_sys);
      chk({row_drive[3:2], col_drive[3:2]}, {4{k[0]}});
    end
    // Reset in mid-run returns pads, lines, nets and configuration to rest.
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({pready, pad_oe_n, pullup_en, row_drive, low_skew_net}, 18'h3e000);
    apb(8'h00, 1'b0, 32'h0);
    chk(rdata, 32'h00007b80);
    summarize();
  end
endmodule // testbench
